// >>> inc/plo_pkg.sv
// constants shared by the indicator override and transceiver control block
//==============================================================================
//==============================================================================
package plo_pkg;
   localparam int ADDR_W = 5;
   localparam int DATA_W = 16;
   // register map
   localparam logic [ADDR_W-1:0] OFF_OVERRIDE = 5'h18;
   localparam logic [ADDR_W-1:0] OFF_CONTROL = 5'h19;
   localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 5'h1c;
   localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 5'h1d;
   // override register fields
   localparam int BIT_EN_SPEED = 5;
   localparam int BIT_EN_LINK = 4;
   localparam int BIT_EN_ACT = 3;
   localparam int BIT_VAL_SPEED = 2;
   localparam int BIT_VAL_LINK = 1;
   localparam int BIT_VAL_ACT = 0;
   localparam int OVR_USED_W = 6;
   // control register fields
   localparam int BIT_AUTO_X = 15;
   localparam int BIT_FORCE_X = 14;
   localparam int BIT_PAUSE_RX = 13;
   localparam int BIT_PAUSE_TX = 12;
   localparam int BIT_INJECT = 11;
   localparam int BIT_PATTERN = 10;
   localparam int BIT_PASS = 9;
   localparam int BIT_RUN = 8;
   localparam int BIT_BYPASS = 7;
   // advertisement fields
   localparam int BIT_ADV_PAUSE = 10;
   localparam int BIT_ADV_ASYM = 11;
   // interrupt status fields
   localparam int IRQ_W = 2;
   localparam int IRQ_FAIL = 0;
   localparam int IRQ_PAUSE = 1;
   localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;
   localparam logic [2:0] IND_RESET = 3'h0;
   localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;
   // stretch timing
   localparam int CLK_PERIOD_PS = 5000;
   localparam int TICK_TIME_US = 1000;
   localparam int TICK_CYCLES = (TICK_TIME_US * 1000000) / CLK_PERIOD_PS;
   localparam int STRETCH_TICKS = 50;
endpackage : plo_pkg

// >>> hdl/plo_stretch.sv
// pulse stretcher for one indicator
`timescale 1ns/1ps
module plo_stretch #(
   parameter int TICKS = plo_pkg::STRETCH_TICKS
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic tick,
   input wire logic raw,
   output logic stretched
);
   import plo_pkg::*;
   localparam int CW = $clog2(TICKS + 1);
   localparam logic [CW-1:0] CNT_LOAD = CW'(TICKS);
   localparam logic [CW-1:0] CNT_ZERO = '0;

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic out;
   } plo_stretch_type;

   plo_stretch_type st;
   plo_stretch_type next_st;

   //==============================================
   // hold the output until the count runs out
   always_comb begin
      next_st = st;
      if (raw) begin
         next_st.cnt = CNT_LOAD;
      end else if (tick && st.cnt != CNT_ZERO) begin
         next_st.cnt = st.cnt - 1'b1;
      end
      next_st.out = raw || next_st.cnt != CNT_ZERO;
   end

   // state register
   always_ff @(posedge clk) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign stretched = st.out;
endmodule : plo_stretch

// >>> hdl/plo_regs.sv
// indicator override and transceiver control registers
`timescale 1ns/1ps
module plo_regs #(
   parameter int TICK_CYCLES = plo_pkg::TICK_CYCLES,
   parameter int STRETCH_TICKS = plo_pkg::STRETCH_TICKS
) (
   input wire logic clk,
   input wire logic rst,
   // register port
   input wire logic [plo_pkg::ADDR_W-1:0] addr,
   input wire logic [plo_pkg::DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [plo_pkg::DATA_W-1:0] rdata,
   output logic irq,
   // strap and negotiation results
   input wire logic strap_auto_crossover,
   input wire logic [plo_pkg::DATA_W-1:0] local_advertisement_reg,
   input wire logic [plo_pkg::DATA_W-1:0] partner_ability_reg,
   input wire logic hcd_full_duplex,
   // raw indicator status
   input wire logic speed_status,
   input wire logic link_status,
   input wire logic activity_status,
   // self-test checker result
   input wire logic selftest_error,
   // indicator pins
   output logic speed_indicator_out,
   output logic link_indicator_out,
   output logic activity_collision_indicator_out,
   // controls to the datapath
   output logic auto_crossover_enable,
   output logic force_crossover,
   output logic pause_rx_enable,
   output logic pause_tx_enable,
   output logic selftest_run,
   output logic selftest_pattern_select,
   output logic selftest_error_inject,
   output logic indicator_stretch_bypass
);
   import plo_pkg::*;
   localparam int TW = $clog2(TICK_CYCLES);
   localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

   typedef struct packed {
      logic [TW-1:0] div;
      logic tick;
      logic en_speed;
      logic en_link;
      logic en_act;
      logic val_speed;
      logic val_link;
      logic val_act;
      logic auto_x;
      logic force_x;
      logic pat;
      logic run;
      logic bypass;
      logic inject;
      logic err_seen;
      logic pass;
      logic [1:0] pause;
      logic [IRQ_W-1:0] irq_stat;
      logic [IRQ_W-1:0] irq_mask;
      logic [DATA_W-1:0] rdata;
      logic [2:0] ind;
   } plo_regs_type;

   plo_regs_type st;
   plo_regs_type next_st;
   logic [2:0] raw;
   logic [2:0] stretched;
   logic [1:0] resolved;
   logic wr_ovr;
   logic wr_ctl;
   logic wr_stat;
   logic wr_mask;

   //==============================================
   // pause resolution: returns {rx, tx} for full duplex
   function automatic logic [1:0] pause_resolve(
      input logic [DATA_W-1:0] loc,
      input logic [DATA_W-1:0] par
   );
      logic lp;
      logic la;
      logic pp;
      logic pa;
      lp = loc[BIT_ADV_PAUSE];
      la = loc[BIT_ADV_ASYM];
      pp = par[BIT_ADV_PAUSE];
      pa = par[BIT_ADV_ASYM];
      pause_resolve[1] = (lp && pp) || (lp && la && !pp && pa);
      pause_resolve[0] = (lp && pp) || (!lp && la && pp && pa);
   endfunction : pause_resolve

   //==============================================
   // write-one-to-clear with set winning
   function automatic logic [IRQ_W-1:0] w1c(
      input logic [IRQ_W-1:0] cur,
      input logic [IRQ_W-1:0] clr,
      input logic [IRQ_W-1:0] set
   );
      w1c = (cur & ~clr) | set;
   endfunction : w1c

   //==============================================
   // address decode
   assign wr_ovr = wr && addr == OFF_OVERRIDE;
   assign wr_ctl = wr && addr == OFF_CONTROL;
   assign wr_stat = wr && addr == OFF_IRQ_STATUS;
   assign wr_mask = wr && addr == OFF_IRQ_MASK;
   assign resolved = pause_resolve(local_advertisement_reg, partner_ability_reg);
   assign raw = {speed_status, link_status, activity_status};

   //==============================================
   // pulse stretchers, one per indicator
   for (genvar i = 0; i < 3; i++) begin : g_stretch
      plo_stretch #(
         .TICKS(STRETCH_TICKS)
      ) u_stretch (
         .clk(clk),
         .rst(rst),
         .tick(st.tick),
         .raw(raw[i]),
         .stretched(stretched[i])
      );
   end

   //==============================================
   // next state of the whole block
   always_comb begin
      logic [IRQ_W-1:0] ev;
      logic [2:0] normal;
      ev = '0;
      normal = '0;
      next_st = st;
      // stretch tick divider
      next_st.tick = st.div == TICK_LAST;
      next_st.div = next_st.tick ? '0 : st.div + 1'b1;
      // override register, upper bits dropped
      if (wr_ovr) begin
         next_st.en_speed = wdata[BIT_EN_SPEED];
         next_st.en_link = wdata[BIT_EN_LINK];
         next_st.en_act = wdata[BIT_EN_ACT];
         next_st.val_speed = wdata[BIT_VAL_SPEED];
         next_st.val_link = wdata[BIT_VAL_LINK];
         next_st.val_act = wdata[BIT_VAL_ACT];
      end
      // control register, read-only bits ignored
      next_st.inject = 1'b0;
      if (wr_ctl) begin
         next_st.auto_x = wdata[BIT_AUTO_X];
         next_st.force_x = wdata[BIT_FORCE_X];
         next_st.inject = wdata[BIT_INJECT];
         next_st.pat = wdata[BIT_PATTERN];
         next_st.run = wdata[BIT_RUN];
         next_st.bypass = wdata[BIT_BYPASS];
      end
      // self-test result latch, cleared while stopped
      if (!st.run) begin
         next_st.err_seen = 1'b0;
      end else if (selftest_error) begin
         next_st.err_seen = 1'b1;
      end
      next_st.pass = st.run && !next_st.err_seen;
      // pause results only for a full duplex outcome
      next_st.pause = hcd_full_duplex ? resolved : 2'b00;
      // interrupt events
      ev[IRQ_FAIL] = next_st.err_seen && !st.err_seen;
      ev[IRQ_PAUSE] = next_st.pause != st.pause;
      next_st.irq_stat = w1c(st.irq_stat, wr_stat ? wdata[IRQ_W-1:0] : IRQ_RESET, ev);
      if (wr_mask) begin
         next_st.irq_mask = wdata[IRQ_W-1:0];
      end
      // indicator selection: forced, raw or stretched
      normal = st.bypass ? raw : stretched;
      next_st.ind[2] = next_st.en_speed ? next_st.val_speed : normal[2];
      next_st.ind[1] = next_st.en_link ? next_st.val_link : normal[1];
      next_st.ind[0] = next_st.en_act ? next_st.val_act : normal[0];
      // read data for one cycle only
      next_st.rdata = DATA_ZERO;
      if (rd) begin
         unique case (addr)
            OFF_OVERRIDE: begin
               next_st.rdata[BIT_EN_SPEED] = st.en_speed;
               next_st.rdata[BIT_EN_LINK] = st.en_link;
               next_st.rdata[BIT_EN_ACT] = st.en_act;
               next_st.rdata[BIT_VAL_SPEED] = st.val_speed;
               next_st.rdata[BIT_VAL_LINK] = st.val_link;
               next_st.rdata[BIT_VAL_ACT] = st.val_act;
            end
            OFF_CONTROL: begin
               next_st.rdata[BIT_AUTO_X] = st.auto_x;
               next_st.rdata[BIT_FORCE_X] = st.force_x;
               next_st.rdata[BIT_PAUSE_RX] = st.pause[1];
               next_st.rdata[BIT_PAUSE_TX] = st.pause[0];
               next_st.rdata[BIT_INJECT] = st.inject;
               next_st.rdata[BIT_PATTERN] = st.pat;
               next_st.rdata[BIT_PASS] = st.pass;
               next_st.rdata[BIT_RUN] = st.run;
               next_st.rdata[BIT_BYPASS] = st.bypass;
            end
            OFF_IRQ_STATUS: begin
               next_st.rdata[IRQ_W-1:0] = st.irq_stat;
            end
            OFF_IRQ_MASK: begin
               next_st.rdata[IRQ_W-1:0] = st.irq_mask;
            end
            default: begin
               next_st.rdata = DATA_ZERO;
            end
         endcase
      end
      // synchronous reset, crossover enable taken from the strap
      if (rst) begin
         next_st = '0;
         next_st.auto_x = strap_auto_crossover;
         next_st.irq_stat = IRQ_RESET;
         next_st.irq_mask = IRQ_RESET;
         next_st.ind = IND_RESET;
      end
   end

   // state register
   always_ff @(posedge clk) begin
      st <= next_st;
   end

   //==============================================
   // outputs
   assign rdata = st.rdata;
   assign irq = |(st.irq_stat & st.irq_mask);
   assign speed_indicator_out = st.ind[2];
   assign link_indicator_out = st.ind[1];
   assign activity_collision_indicator_out = st.ind[0];
   assign auto_crossover_enable = st.auto_x;
   assign force_crossover = st.force_x;
   assign pause_rx_enable = st.pause[1];
   assign pause_tx_enable = st.pause[0];
   assign selftest_run = st.run;
   assign selftest_pattern_select = st.pat;
   assign selftest_error_inject = st.inject;
   assign indicator_stretch_bypass = st.bypass;

   //==============================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // helper: a read of the override or control register was taken last cycle
   logic h_rd_ovr;
   logic h_rd_ctl;
   logic [5:0] h_ovr;
   always_ff @(posedge clk) begin
      h_rd_ovr <= rd && addr == OFF_OVERRIDE;
      h_rd_ctl <= rd && addr == OFF_CONTROL;
      h_ovr <= {st.en_speed, st.en_link, st.en_act, st.val_speed, st.val_link, st.val_act};
   end

   property p_rsvd_zero;
      h_rd_ovr |-> rdata[DATA_W-1:OVR_USED_W] == '0;
   endproperty
   a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits not zero");

   property p_speed_force;
      wr_ovr && wdata[BIT_EN_SPEED] |=> speed_indicator_out == $past(wdata[BIT_VAL_SPEED]);
   endproperty
   a_speed_force: assert property (p_speed_force) else $error("speed force late");

   property p_link_normal;
      !st.en_link && st.bypass && !wr_ovr |=> link_indicator_out == $past(link_status);
   endproperty
   a_link_normal: assert property (p_link_normal) else $error("link not normal");

   property p_act_force;
      st.en_act && !wr_ovr |=> activity_collision_indicator_out == $past(st.val_act);
   endproperty
   a_act_force: assert property (p_act_force) else $error("activity force wrong");

   property p_read_stored;
      h_rd_ovr |-> rdata[OVR_USED_W-1:0] == h_ovr;
   endproperty
   a_read_stored: assert property (p_read_stored) else $error("override read wrong");

   property p_strap;
      $fell(rst) |-> auto_crossover_enable == $past(strap_auto_crossover);
   endproperty
   a_strap: assert property (p_strap) else $error("strap not taken");

   property p_pause_half;
      !hcd_full_duplex ##1 !hcd_full_duplex |-> !pause_rx_enable && !pause_tx_enable;
   endproperty
   a_pause_half: assert property (p_pause_half) else $error("pause in half duplex");

   property p_pause_both;
      hcd_full_duplex && local_advertisement_reg[BIT_ADV_PAUSE]
         && partner_ability_reg[BIT_ADV_PAUSE] |=> pause_rx_enable && pause_tx_enable;
   endproperty
   a_pause_both: assert property (p_pause_both) else $error("symmetric pause lost");

   property p_inject_once;
      wr_ctl && wdata[BIT_INJECT] |=> selftest_error_inject ##1 !selftest_error_inject;
   endproperty
   a_inject_once: assert property (p_inject_once) else $error("inject not one pulse");

   property p_fail_latch;
      st.run && selftest_error ##1 st.run |=> !st.pass;
   endproperty
   a_fail_latch: assert property (p_fail_latch) else $error("fail not latched");

   property p_stop_clear;
      !st.run |=> !st.pass;
   endproperty
   a_stop_clear: assert property (p_stop_clear) else $error("pass not cleared");

   property p_bypass_raw;
      st.bypass && !st.en_speed && !wr_ovr |=> speed_indicator_out == $past(speed_status);
   endproperty
   a_bypass_raw: assert property (p_bypass_raw) else $error("bypass not raw");

   property p_read_once;
      h_rd_ctl ##1 !h_rd_ovr && !h_rd_ctl && !$past(rd) |-> rdata == DATA_ZERO;
   endproperty
   a_read_once: assert property (p_read_once) else $error("read data held");
endmodule : plo_regs

// >>> dv/plo_far_model.sv
// self-test checker model on the far side of the control block
`timescale 1ns/1ps
module plo_far_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic selftest_run,
   input wire logic selftest_error_inject,
   output logic selftest_error
);
   //==========================================================================
   // checker
   // one forced error seen per inject pulse, only while the test runs
   always_ff @(posedge clk) begin
      if (rst) begin
         selftest_error <= 1'b0;
      end else begin
         selftest_error <= selftest_error_inject & selftest_run;
      end
   end
endmodule : plo_far_model

// >>> dv/tb_top.sv
// self-checking bench for the indicator override and control registers
`timescale 1ns/1ps
module tb_top;
   import plo_pkg::*;
   logic clk = 0, rst = 1, wr = 0, rd = 0, strap = 1, fd = 0, sp = 0, lk = 0, ac = 0;
   logic [ADDR_W-1:0] addr = '0;
   logic [DATA_W-1:0] wdata = '0, rdata, ladv = '0, padv = '0;
   logic irq, o_sp, o_lk, o_ac, ax, fx, prx, ptx, run, pat, inj, byp, err;
   logic rd_p = 0, mon_on = 0;
   logic [31:0] s = 32'h48a5a897;
   logic [DATA_W-1:0] exp_q[$];
   logic [DATA_W-1:0] d, e;
   int n_fail = 0, comparisons = 0, cyc = 0;

   //==========================================================================
   // clock, design and far side
   always #2.5 clk = ~clk;
   plo_regs #(.TICK_CYCLES(4), .STRETCH_TICKS(3)) i_dut (.clk(clk), .rst(rst), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
      .strap_auto_crossover(strap), .local_advertisement_reg(ladv),
      .partner_ability_reg(padv), .hcd_full_duplex(fd), .speed_status(sp),
      .link_status(lk), .activity_status(ac), .selftest_error(err),
      .speed_indicator_out(o_sp), .link_indicator_out(o_lk),
      .activity_collision_indicator_out(o_ac), .auto_crossover_enable(ax),
      .force_crossover(fx), .pause_rx_enable(prx), .pause_tx_enable(ptx),
      .selftest_run(run), .selftest_pattern_select(pat), .selftest_error_inject(inj),
      .indicator_stretch_bypass(byp));
   plo_far_model i_far (.clk(clk), .rst(rst), .selftest_run(run),
      .selftest_error_inject(inj), .selftest_error(err));

   //==========================================================================
   // helpers
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : lfsr

   task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] ex);
      comparisons++;
      if (seen !== ex) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, ex, seen);
      end
   endtask : check

   task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] ex);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      exp_q.push_back(ex);
      @(posedge clk);
      rd <= 1'b0;
   endtask : rd_reg

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick

   task automatic final_report;
      if (n_fail == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : final_report

   //==========================================================================
   // read monitor: data in the cycle after the strobe only, zero elsewhere
   always @(posedge clk) begin
      rd_p <= rd;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         final_report();
      end
   end
   always @(negedge clk) begin
      if (mon_on && rd_p) begin
         check("rdata", rdata, exp_q.pop_front());
      end else if (mon_on) begin
         check("rdata idle", rdata, 16'h0000);
      end
   end

   //==========================================================================
   // main sequence
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      tick(1);
      mon_on = 1'b1;
      check("strap", ax, 16'h0001);
      rd_reg(OFF_OVERRIDE, 16'h0000);
      rd_reg(OFF_CONTROL, 16'h8000);
      wr_reg(5'h05, 16'hffff);
      rd_reg(5'h05, 16'h0000);
      rd_reg(OFF_OVERRIDE, 16'h0000);
      // control bits with read-only bits written as well
      for (int i = 0; i < 12; i++) begin
         s = lfsr(s);
         d = s[15:0] & 16'hf780;
         wr_reg(OFF_CONTROL, d);
         tick(3);
         check("auto_x", ax, {15'h0, d[15]});
         check("force_x", fx, {15'h0, d[14]});
         check("run", run, {15'h0, d[8]});
         check("pattern", pat, {15'h0, d[10]});
         check("bypass", byp, {15'h0, d[7]});
         e = (d & 16'hc580) | (d[8] ? 16'h0200 : 16'h0000);
         rd_reg(OFF_CONTROL, e);
      end
      // overrides against raw status with stretching bypassed
      // negotiation is off on this bench, so software keeps crossover cleared
      wr_reg(OFF_CONTROL, 16'h0080);
      for (int i = 0; i < 16; i++) begin
         s = lfsr(s);
         @(posedge clk);
         {sp, lk, ac} <= s[18:16];
         wr_reg(OFF_OVERRIDE, s[15:0]);
         tick(1);
         check("spd", o_sp, {15'h0, s[5] ? s[2] : s[18]});
         check("lnk", o_lk, {15'h0, s[4] ? s[1] : s[17]});
         check("act", o_ac, {15'h0, s[3] ? s[0] : s[16]});
         rd_reg(OFF_OVERRIDE, {10'h0, s[5:0]});
      end
      // stretching holds a short pulse, bypass shows the raw level
      @(posedge clk);
      {sp, lk, ac} <= 3'h0;
      wr_reg(OFF_OVERRIDE, 16'h0000);
      wr_reg(OFF_CONTROL, 16'h0000);
      ac <= 1'b1;
      repeat (3) @(posedge clk);
      ac <= 1'b0;
      tick(3);
      check("stretched", o_ac, 16'h0001);
      wr_reg(OFF_CONTROL, 16'h0080);
      tick(1);
      check("raw", o_ac, 16'h0000);
      wr_reg(OFF_CONTROL, 16'h0000);
      // every pause advertisement combination, half and full duplex
      for (int i = 0; i < 32; i++) begin
         s = lfsr(s);
         @(posedge clk);
         ladv <= (s[15:0] & 16'hf3ff) | {4'h0, i[1:0], 10'h0};
         padv <= (s[31:16] & 16'hf3ff) | {4'h0, i[3:2], 10'h0};
         fd <= i[4];
         tick(2);
         e[13] = i[4] & ((i[0] & i[2]) | (i[0] & i[1] & !i[2] & i[3]));
         e[12] = i[4] & ((i[0] & i[2]) | (!i[0] & i[1] & i[2] & i[3]));
         check("pause_rx", prx, {15'h0, e[13]});
         check("pause_tx", ptx, {15'h0, e[12]});
         rd_reg(OFF_CONTROL, {2'b00, e[13:12], 12'h000});
      end
      // interrupt mask and clear, then a single injected error
      wr_reg(OFF_IRQ_MASK, 16'h0002);
      tick(1);
      check("irq pause", irq, 16'h0001);
      wr_reg(OFF_IRQ_STATUS, 16'h0003);
      tick(1);
      check("irq clr", irq, 16'h0000);
      rd_reg(OFF_IRQ_STATUS, 16'h0000);
      wr_reg(OFF_IRQ_MASK, 16'h0001);
      rd_reg(OFF_IRQ_MASK, 16'h0001);
      wr_reg(OFF_CONTROL, 16'h0100);
      tick(3);
      rd_reg(OFF_CONTROL, 16'h3300);
      wr_reg(OFF_CONTROL, 16'h0900);
      #1;
      check("inject", inj, 16'h0001);
      tick(1);
      check("inject end", inj, 16'h0000);
      tick(3);
      check("irq fail", irq, 16'h0001);
      rd_reg(OFF_CONTROL, 16'h3100);
      rd_reg(OFF_IRQ_STATUS, 16'h0001);
      wr_reg(OFF_CONTROL, 16'h0000);
      tick(3);
      rd_reg(OFF_CONTROL, 16'h3000);
      // second reset with the strap low
      tick(2);
      @(posedge clk);
      rst <= 1'b1;
      strap <= 1'b0;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      tick(1);
      check("strap low", ax, 16'h0000);
      rd_reg(OFF_CONTROL, 16'h3000);
      tick(3);
      final_report();
   end
endmodule : tb_top
